// File: src/bootstrap_mode_loader.sv
// Overview of operation
// - Fetch start vector from bootstrap vector bytes
// - Select lines three and four: serial loader
// - Lines two, three high, four low: jump RAM
// - Non-zero EPROM byte lights red and stops
// - Erase passed, line one low: halt until high
// - Erase EEPROM bank, check, then clear security
// - Line two low: fixed five millisecond pulse
// - Ascending source order, skip non-array addresses
// - Gather sixteen bytes, then program them together
// - Skip erased sixteen-byte block or EEPROM byte
// - Data on port A, address on outputs
// - Request/acknowledge handshake; tied lines bypass it
// - Green toggles about three hertz while programming
// - Verify arrays against source; green pass, red fail
// - First compare output high on entering bootstrap
// - First byte below threshold counts following bytes
// - Large count fills all RAM; idle timeout executes
// - Loader mode redirects interrupts to RAM jumps
// - Pseudo-vectors three bytes apart, fixed order
// - Lines one, two high: EPROM only, EEPROM erased but not programmed
`timescale 1ns/1ps
`default_nettype none
module bootstrap_mode_loader
	import boot_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int RX_IDLE_CYCLES = RX_IDLE_CYC,
	parameter int BLINK_CYCLES = BLINK_CYC,
	parameter logic [14:0] EPROM_LO = 15'h0400,
	parameter logic [14:0] EPROM_HI = 15'h7DFF,
	parameter logic [14:0] RAM_LAST = 15'h02FF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Entry and mode pins
	input wire logic irq_elevated,
	input wire logic capture_input_one,
	input wire logic mode_select_one,
	input wire logic mode_select_two,
	input wire logic mode_select_three,
	input wire logic mode_select_four,
	// Parallel source
	input wire logic [7:0] port_a_in,
	input wire logic handshake_line_b,
	output logic handshake_line_a,
	output logic [7:0] port_b_out,
	output logic [4:0] port_c_out,
	output logic compare_output_one,
	output logic compare_output_two,
	// Indicators
	output logic green_led,
	output logic red_led,
	// Internal arrays and RAM
	input wire logic [7:0] mem_rdata,
	output logic [14:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic ram_we,
	output logic prog_pulse,
	output logic prog_ee,
	output logic ee_erase,
	output logic security_lock_bit_clear,
	// Serial receiver, same clock
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	// Core hand-off
	input wire logic [2:0] int_index,
	output logic [15:0] start_vector,
	output logic [15:0] pseudo_vector,
	output logic vector_redirect,
	output logic exec_start,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);

	typedef struct packed {
		state_e state;
		logic [6:0] pin_s1;
		logic [6:0] pin_s2;
		logic [7:0] pa_s1;
		logic [7:0] pa_s2;
		logic [1:0] hold;
		logic boot;
		logic [3:0] mode;
		logic [14:0] addr;
		logic [31:0] timer;
		logic [31:0] blink;
		logic phase;
		logic [1:0] hs;
		logic [7:0] dat;
		logic [15:0][7:0] grp;
		logic [3:0] wi;
		logic nz;
		logic verify;
		logic ee_en;
		logic first;
		logic cnt_mode;
		logic [7:0] cnt;
		logic req;
		logic [14:0] ext_addr;
		logic cmp1;
		logic cmp2;
		logic green;
		logic red;
		logic [14:0] maddr;
		logic [7:0] wdata;
		logic we;
		logic rwe;
		logic prog;
		logic pee;
		logic erase;
		logic sec;
		logic [15:0] vec;
		logic [15:0] pseudo;
		logic redir;
		logic exec;
		logic a_ph;
		logic a_wr;
		logic [7:0] a_adr;
		logic [31:0] rdata;
		logic [31:0] ptime;
		logic rdy;
	} st_s;

	st_s st;
	st_s next_st;

	////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] pv(input logic [2:0] i);
		pv = (i > 3'h5) ? 16'h0000 : PSEUDO_BASE + PSEUDO_STEP * 16'(i);
	endfunction

	function automatic logic in_eprom(input logic [14:0] a);
		in_eprom = (a >= EPROM_LO) && (a <= EPROM_HI);
	endfunction

	function automatic logic in_ee(input logic [14:0] a);
		in_ee = (a >= EE_LO) && (a <= EE_HI);
	endfunction

	// Jump over unused space so a pass costs bytes, not addresses
	function automatic logic [14:0] skip_to(input logic [14:0] a);
		if (a < EE_LO)
			skip_to = EE_LO;
		else if (a < EPROM_LO)
			skip_to = EPROM_LO;
		else if (a < SRC_LAST)
			skip_to = SRC_LAST;
		else
			skip_to = 15'h0000;
	endfunction

	// Synchronised pin aliases
	logic irq_s, cap_s, ack_s;
	logic [3:0] pd_s;
	assign irq_s = st.pin_s2[0];
	assign cap_s = st.pin_s2[1];
	assign pd_s = st.pin_s2[5:2];
	assign ack_s = st.pin_s2[6];

	logic [31:0] pulse_len;
	logic [31:0] status;
	assign pulse_len = st.mode[1] ? st.ptime : 32'(PROG_CYCLES);
	assign status = {18'h0, st.redir, st.verify, st.mode, st.boot, st.red,
		st.green, st.state};

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.pin_s1 = {handshake_line_b, mode_select_four,
			mode_select_three, mode_select_two, mode_select_one,
			capture_input_one, irq_elevated};
		next_st.pin_s2 = st.pin_s1;
		next_st.pa_s1 = port_a_in;
		next_st.pa_s2 = st.pa_s1;
		next_st.exec = 1'b0;
		next_st.sec = 1'b0;
		next_st.we = 1'b0;
		next_st.rwe = 1'b0;
		next_st.pseudo = st.redir ? pv(int_index) : 16'h0000;
		unique case (st.state)
			S_HOLD: begin
				// Sync delay makes this the pin level right after release
				if (st.hold == 2'(HOLD_CLKS)) begin
					next_st.boot = irq_s & cap_s;
					next_st.mode = pd_s;
					next_st.maddr = VEC_HI_ADDR;
					next_st.cmp1 = irq_s & cap_s;
					next_st.state = (irq_s & cap_s) ? S_VEC1 : S_SINGLE;
				end else begin
					next_st.hold = st.hold + 2'h1;
				end
			end
			S_VEC1: begin
				next_st.vec[15:8] = mem_rdata;
				next_st.maddr = VEC_LO_ADDR;
				next_st.state = S_VEC2;
			end
			S_VEC2: begin
				next_st.vec[7:0] = mem_rdata;
				next_st.addr = EPROM_LO;
				next_st.phase = 1'b0;
				next_st.ee_en = !(st.mode[0] & st.mode[1]);
				if (st.mode[3:2] == 2'b11) begin
					next_st.state = S_SER;
					next_st.redir = 1'b1;
					next_st.first = 1'b1;
					next_st.addr = RAM_BASE;
					next_st.timer = 32'h0;
				end else if (st.mode[3:1] == 3'b011) begin
					next_st.exec = 1'b1;
					next_st.state = S_RUN;
				end else if (st.mode == 4'b1010) begin
					next_st.verify = 1'b1;
					next_st.addr = 15'h0000;
					next_st.hs = 2'h0;
					next_st.state = S_FETCH;
				end else begin
					next_st.state = S_BLANK;
				end
			end
			S_BLANK, S_EECHK: begin
				// Array reads take one cycle, so address then check
				next_st.phase = !st.phase;
				if (!st.phase) begin
					next_st.maddr = st.addr;
				end else if (mem_rdata != ((st.state == S_BLANK) ?
					ERASED_EPROM : ERASED_EE)) begin
					next_st.red = 1'b1;
					next_st.state = S_STOP;
				end else if (st.state == S_BLANK && st.addr == EPROM_HI) begin
					next_st.green = 1'b1;
					next_st.state = S_PD1;
				end else if (st.state == S_EECHK && st.addr == EE_HI) begin
					next_st.sec = 1'b1;
					next_st.state = S_SEC;
				end else begin
					next_st.addr = st.addr + 15'h1;
				end
			end
			S_PD1: begin
				if (pd_s[0]) begin
					next_st.erase = 1'b1;
					next_st.timer = 32'h0;
					next_st.state = S_ERASE;
				end
			end
			S_ERASE: begin
				next_st.timer = st.timer + 32'h1;
				if (st.timer == 32'(ERASE_CYCLES - 1)) begin
					next_st.erase = 1'b0;
					next_st.addr = EE_LO;
					next_st.phase = 1'b0;
					next_st.state = S_EECHK;
				end
			end
			S_SEC: begin
				next_st.addr = 15'h0000;
				next_st.hs = 2'h0;
				next_st.grp = '0;
				next_st.nz = 1'b0;
				next_st.blink = 32'h0;
				next_st.state = S_FETCH;
			end
			S_FETCH: begin
				unique case (st.hs)
					2'h0: begin
						if (!in_eprom(st.addr) &&
							!(in_ee(st.addr) && st.ee_en)) begin
							if (st.addr == SRC_LAST) begin
								next_st.state = st.verify ? S_DONE : S_FETCH;
								next_st.green = st.verify ? 1'b1 : st.green;
								next_st.verify = 1'b1;
							end
							next_st.addr = skip_to(st.addr);
						end else begin
							next_st.ext_addr = st.addr;
							// Top bits move with the rest of the address
							next_st.cmp1 = st.addr[13];
							next_st.cmp2 = st.addr[14];
							next_st.req = 1'b1;
							next_st.hs = 2'h1;
						end
					end
					2'h1: begin
						if (ack_s) begin
							next_st.dat = st.pa_s2;
							next_st.req = 1'b0;
							next_st.hs = 2'h2;
						end
					end
					2'h2: begin
						if (!ack_s) begin
							next_st.maddr = st.addr;
							next_st.hs = 2'h3;
						end
					end
					2'h3: begin
						next_st.hs = 2'h0;
						if (st.verify) begin
							if (mem_rdata != st.dat) begin
								next_st.red = 1'b1;
								next_st.green = 1'b0;
								next_st.state = S_STOP;
							end else begin
								next_st.addr = st.addr + 15'h1;
							end
						end else if (in_ee(st.addr)) begin
							if (st.dat != ERASED_EE) begin
								next_st.we = 1'b1;
								next_st.wdata = st.dat;
								next_st.pee = 1'b1;
								next_st.prog = 1'b1;
								next_st.timer = 32'h0;
								next_st.state = S_PROG;
							end else begin
								next_st.addr = st.addr + 15'h1;
							end
						end else begin
							next_st.grp[st.addr[3:0]] = st.dat;
							next_st.nz = st.nz | (st.dat != ERASED_EPROM);
							if (st.addr[3:0] == 4'hF || st.addr == EPROM_HI) begin
								if (st.nz | (st.dat != ERASED_EPROM)) begin
									next_st.wi = 4'h0;
									next_st.state = S_LOAD;
								end else begin
									next_st.addr = st.addr + 15'h1;
								end
							end else begin
								next_st.addr = st.addr + 15'h1;
							end
						end
					end
				endcase
			end
			S_LOAD: begin
				// Untaken bytes stay erased so they program nothing
				next_st.we = 1'b1;
				next_st.maddr = {st.addr[14:4], st.wi};
				next_st.wdata = st.grp[st.wi];
				next_st.wi = st.wi + 4'h1;
				if (st.wi == 4'hF) begin
					next_st.timer = 32'h0;
					next_st.pee = 1'b0;
					// Pulse starts here so it lasts the full count
					next_st.prog = 1'b1;
					next_st.state = S_PROG;
				end
			end
			S_PROG: begin
				next_st.prog = 1'b1;
				next_st.timer = st.timer + 32'h1;
				if (st.timer == pulse_len - 32'h1) begin
					next_st.prog = 1'b0;
					next_st.pee = 1'b0;
					next_st.grp = '0;
					next_st.nz = 1'b0;
					next_st.addr = st.addr + 15'h1;
					next_st.state = S_FETCH;
				end
			end
			S_SER: begin
				next_st.timer = st.timer + 32'h1;
				if (rx_valid) begin
					next_st.timer = 32'h0;
					next_st.first = 1'b0;
					if (st.first) begin
						next_st.cnt_mode = rx_data < COUNT_LIMIT;
						next_st.cnt = rx_data;
						if (rx_data == 8'h00) begin
							next_st.exec = 1'b1;
							next_st.state = S_RUN;
						end
					end else begin
						next_st.rwe = 1'b1;
						next_st.maddr = st.addr;
						next_st.wdata = rx_data;
						next_st.addr = st.addr + 15'h1;
						next_st.cnt = st.cnt - 8'h1;
						if ((st.cnt_mode && st.cnt == 8'h01) ||
							st.addr == RAM_LAST) begin
							next_st.exec = 1'b1;
							next_st.state = S_RUN;
						end
					end
				end else if (st.timer == 32'(RX_IDLE_CYCLES - 1)) begin
					next_st.exec = 1'b1;
					next_st.state = S_RUN;
				end
			end
			S_SINGLE, S_STOP, S_DONE, S_RUN: begin
			end
			default: next_st.state = S_STOP;
		endcase
		// Slow blink without a second clock
		if ((st.state == S_FETCH || st.state == S_LOAD ||
			st.state == S_PROG) && !st.verify) begin
			next_st.blink = st.blink + 32'h1;
			if (st.blink == 32'(BLINK_CYCLES - 1)) begin
				next_st.blink = 32'h0;
				next_st.green = !st.green;
			end
		end
		// Ready from a flop; low for one cycle after reset
		next_st.rdy = 1'b1;
		// AHB-Lite: zero wait, data read in the address phase
		next_st.a_ph = hsel & hready & htrans[1];
		if (hsel & hready & htrans[1]) begin
			next_st.a_wr = hwrite;
			next_st.a_adr = haddr[7:0];
			unique case (haddr[7:0])
				REG_STATUS: next_st.rdata = status;
				REG_PTIME: next_st.rdata = st.ptime;
				REG_VECTOR: next_st.rdata = {st.pseudo, st.vec};
				default: next_st.rdata = 32'h0;
			endcase
		end
		if (st.a_ph && st.a_wr && st.a_adr == REG_PTIME)
			next_st.ptime = hwdata;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
			st.state <= S_HOLD;
			st.ptime <= 32'(PROG_CYC);
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign handshake_line_a = st.req;
	assign port_b_out = st.ext_addr[7:0];
	assign port_c_out = st.ext_addr[12:8];
	assign compare_output_one = st.cmp1;
	assign compare_output_two = st.cmp2;
	assign green_led = st.green;
	assign red_led = st.red;
	assign mem_addr = st.maddr;
	assign mem_wdata = st.wdata;
	assign mem_we = st.we;
	assign ram_we = st.rwe;
	assign prog_pulse = st.prog;
	assign prog_ee = st.pee;
	assign ee_erase = st.erase;
	assign security_lock_bit_clear = st.sec;
	assign start_vector = st.vec;
	assign pseudo_vector = st.pseudo;
	assign vector_redirect = st.redir;
	assign exec_start = st.exec;
	assign hreadyout = st.rdy;
	assign hrdata = st.rdata;
	assign hresp = st.a_ph & 1'b0;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_vector_fetch: assert property (st.state == S_VEC1 |=>
		st.vec[15:8] == $past(mem_rdata) && st.maddr == VEC_LO_ADDR)
		else $error("start vector high byte not taken");
	a_entry_cmp: assert property (st.state == S_VEC1 |-> st.cmp1)
		else $error("compare output one low in bootstrap");
	a_jump_ram: assert property ((st.state == S_VEC2 &&
		st.mode[3:1] == 3'b011) |=> st.exec && st.state == S_RUN && !st.redir)
		else $error("jump to RAM not taken");
	a_serial_redir: assert property (st.state == S_SER |-> st.redir)
		else $error("serial loader without redirect");
	a_pseudo_sci: assert property ((st.redir && int_index == 3'h5) |=>
		st.pseudo == 16'h0063)
		else $error("serial pseudo-vector wrong");
	a_red_stop: assert property ((st.state == S_BLANK && st.phase &&
		mem_rdata != 8'h00) |=> st.red ##1 st.state == S_STOP)
		else $error("non-erased byte not flagged");
	a_pd1_halt: assert property ((st.state == S_PD1 && !pd_s[0]) |=>
		st.state == S_PD1 && !st.erase)
		else $error("left halt without line one");
	a_prog_time: assert property (($fell(st.prog) && !st.mode[1]) |->
		$past(st.timer) == 32'(PROG_CYCLES - 1))
		else $error("programming pulse length wrong");
	a_ack_sample: assert property ((st.state == S_FETCH && st.hs == 2'h1 &&
		ack_s) |=> st.dat == $past(st.pa_s2) && !st.req &&
		st.ext_addr == $past(st.ext_addr))
		else $error("data not taken on acknowledge");
	a_eeprom_skip: assert property ((st.mode[1:0] == 2'b11 &&
		st.state != S_HOLD) |-> !st.pee)
		else $error("EEPROM touched in EPROM-only mode");

endmodule // bootstrap_mode_loader
`default_nettype wire

// File: src/boot_pkg.sv
package boot_pkg;
	localparam int CLK_MHZ = 50;
	localparam int HOLD_CLKS = 2;
	localparam int PROG_TIME_US = 5000;
	localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_TIME_MS = 2500;
	localparam int ERASE_CYC = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int RX_IDLE_TIME_US = 5000;
	localparam int RX_IDLE_CYC = RX_IDLE_TIME_US * CLK_MHZ;
	localparam int BLINK_HZ = 3;
	localparam int BLINK_CYC = CLK_MHZ * 1000000 / (2 * BLINK_HZ);
	localparam logic [14:0] VEC_HI_ADDR = 15'h7FEE;
	localparam logic [14:0] VEC_LO_ADDR = 15'h7FEF;
	localparam logic [14:0] RAM_BASE = 15'h0050;
	localparam logic [14:0] EE_LO = 15'h0100;
	localparam logic [14:0] EE_HI = 15'h01FF;
	localparam logic [14:0] SRC_LAST = 15'h7FFF;
	localparam logic [7:0] COUNT_LIMIT = 8'hB0;
	localparam logic [15:0] PSEUDO_BASE = 16'h0054;
	localparam logic [15:0] PSEUDO_STEP = 16'h0003;
	localparam logic [7:0] ERASED_EPROM = 8'h00;
	localparam logic [7:0] ERASED_EE = 8'hFF;
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_PTIME = 8'h04;
	localparam logic [7:0] REG_VECTOR = 8'h08;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_GREEN = 5;
	localparam int ST_RED = 6;
	localparam int ST_BOOT = 7;
	localparam int ST_MODE_LSB = 8;
	localparam int ST_VERIFY = 12;
	localparam int ST_REDIR = 13;
	typedef enum logic [4:0] {
		S_HOLD = 5'h00, S_VEC1 = 5'h01, S_VEC2 = 5'h02,
		S_SINGLE = 5'h03, S_BLANK = 5'h04, S_STOP = 5'h05,
		S_PD1 = 5'h06, S_ERASE = 5'h07, S_EECHK = 5'h08,
		S_SEC = 5'h09, S_FETCH = 5'h0A, S_LOAD = 5'h0B,
		S_PROG = 5'h0C, S_DONE = 5'h0D, S_SER = 5'h0E,
		S_RUN = 5'h0F
	} state_e;
endpackage

// File: sim/parallel_source.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_source
	import boot_pkg::*;
#(
	parameter logic [14:0] ROM_LO = 15'h0400,
	parameter logic [14:0] ROM_HI = 15'h041F
) (
	// Clock and strap
	input wire logic clk,
	input wire logic bypass,
	// Device side
	input wire logic req,
	input wire logic [14:0] addr,
	output logic [7:0] data,
	output logic ack,
	// Faults seen
	output int bad
);
	logic ack_q;
	logic req_d;
	logic [7:0] last;
	logic [14:0] held;
	logic [14:0] prev;
	int wait_n;
	////////////////////////////////////////
	function automatic logic in_ee(input logic [14:0] a);
		return a >= EE_LO && a <= EE_HI;
	endfunction
	function automatic logic [7:0] src(input logic [14:0] a);
		if (a >= ROM_LO + 15'h0010 && a <= ROM_LO + 15'h001F)
			return {4'hA, a[3:0]};
		if (in_ee(a))
			return ERASED_EE;
		return ERASED_EPROM;
	endfunction
	initial begin
		ack_q = 1'b0;
		req_d = 1'b0;
		last = 8'h00;
		held = 15'h0000;
		prev = 15'h7FFF;
		wait_n = 0;
		bad = 0;
	end
	// Tied lines: acknowledge is the request itself
	assign ack = bypass ? req : ack_q;
	// Idle bus shows stale inverted data so a early sample fails
	assign data = (bypass || ack_q) ? src(addr) : ~last;
	always @(posedge clk) begin
		req_d <= req;
		if (req && !req_d) begin
			held <= addr;
			prev <= addr;
			if (!in_ee(addr) && (addr < ROM_LO || addr > ROM_HI))
				bad <= bad + 1;
			else if (addr <= prev && in_ee(addr) == in_ee(prev)
				&& addr != ROM_LO && addr != EE_LO)
				bad <= bad + 1;
		end
		if ((req_d || ack_q) && addr !== held)
			bad <= bad + 1;
		if (!req) begin
			ack_q <= 1'b0;
			wait_n <= 0;
		end else if (!ack_q) begin
			// Slow answer: four cycles of think time
			wait_n <= wait_n + 1;
			if (wait_n == 3) begin
				ack_q <= 1'b1;
				last <= src(addr);
			end
		end
	end
endmodule // parallel_source
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import boot_pkg::*;
;
	localparam int PROG_N = 20;
	localparam int ERASE_N = 30;
	localparam logic [14:0] LO = 15'h0400;
	logic clk, sys_rst, irq_elevated, capture_input_one;
	logic mode_select_one, mode_select_two, mode_select_three;
	logic mode_select_four, handshake_line_b, handshake_line_a;
	logic [7:0] port_a_in, port_b_out, mem_rdata, mem_wdata, rx_data;
	logic [4:0] port_c_out;
	logic compare_output_one, compare_output_two, green_led, red_led;
	logic [14:0] mem_addr;
	logic mem_we, ram_we, prog_pulse, prog_ee, ee_erase, rx_valid;
	logic security_lock_bit_clear, vector_redirect, exec_start;
	logic [2:0] int_index;
	logic [15:0] start_vector, pseudo_vector;
	logic hsel, hwrite, hreadyout, hresp, bypass, green_d;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [7:0] mem [0:32767];
	int err_total, compares, bad, cyc;
	int we_n, ex_n, ram_n, pee_n, sec_n, pw, pw_last, ew, ew_last, tog;
	bootstrap_mode_loader #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N),
		.RX_IDLE_CYCLES(50), .BLINK_CYCLES(8), .EPROM_LO(LO),
		.EPROM_HI(15'h041F)) i_dut (.clk, .sys_rst, .irq_elevated,
		.capture_input_one, .mode_select_one, .mode_select_two,
		.mode_select_three, .mode_select_four, .port_a_in,
		.handshake_line_b, .handshake_line_a, .port_b_out, .port_c_out,
		.compare_output_one, .compare_output_two, .green_led, .red_led,
		.mem_rdata, .mem_addr, .mem_wdata, .mem_we, .ram_we, .prog_pulse,
		.prog_ee, .ee_erase, .security_lock_bit_clear, .rx_valid,
		.rx_data, .int_index, .start_vector, .pseudo_vector,
		.vector_redirect, .exec_start, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
		.hresp);
	parallel_source #(.ROM_LO(LO), .ROM_HI(15'h041F)) i_src (.clk,
		.bypass, .req(handshake_line_a), .addr({compare_output_two,
		compare_output_one, port_c_out, port_b_out}), .data(port_a_in),
		.ack(handshake_line_b), .bad);
	////////////////////////////////////////
	always #10 clk = ~clk;
	assign mem_rdata = mem[mem_addr];
	always @(posedge clk) begin
		if (mem_we || ram_we)
			mem[mem_addr] <= mem_wdata;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			tally_and_finish();
		end
		green_d <= green_led;
		pw <= prog_pulse ? pw + 1 : 0;
		ew <= ee_erase ? ew + 1 : 0;
		if (sys_rst) begin
			{we_n, ex_n, ram_n, pee_n, sec_n, tog} <= '0;
			{pw_last, ew_last} <= '0;
		end else begin
			we_n <= we_n + int'(mem_we);
			ex_n <= ex_n + int'(exec_start);
			ram_n <= ram_n + int'(ram_we);
			sec_n <= sec_n + int'(security_lock_bit_clear);
			pee_n <= pee_n + int'(prog_ee && prog_pulse);
			tog <= tog + int'(prog_pulse && green_led !== green_d);
			if (!prog_pulse && pw != 0)
				pw_last <= pw;
			if (!ee_erase && ew != 0)
				ew_last <= ew;
		end
	end
	////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Memory refill happens inside reset so no write races it
	task automatic rst(input logic [3:0] m);
		@(posedge clk);
		sys_rst <= 1'b1;
		irq_elevated <= 1'b1;
		capture_input_one <= 1'b1;
		{mode_select_four, mode_select_three, mode_select_two,
			mode_select_one} <= m;
		@(posedge clk);
		for (int i = 0; i < 32768; i++)
			mem[i] = (i >= EE_LO && i <= EE_HI) ? ERASED_EE : ERASED_EPROM;
		mem[VEC_HI_ADDR] = 8'h12;
		mem[VEC_LO_ADDR] = 8'h34;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
	endtask
	task automatic send(input logic [7:0] b);
		rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	////////////////////////////////////////
	task automatic t_jump();
		logic [31:0] r;
		rst(4'h6);
		bus(1'b0, REG_PTIME, 32'h0, r);
		check("ptime_reset", r, 32'h0003D090);
		for (int n = 0; n < 300 && ex_n == 0; n++) @(posedge clk);
		check("exec_start", ex_n, 32'h1);
		check("compare_one", compare_output_one, 32'h1);
		check("start_vector", start_vector, 32'h1234);
		bus(1'b0, REG_STATUS, 32'h0, r);
		check("boot_flag", r[ST_BOOT], 32'h1);
		check("mode_field", r[ST_MODE_LSB +: 4], 32'h6);
		bus(1'b1, REG_PTIME, 32'h33, r);
		bus(1'b0, REG_PTIME, 32'h0, r);
		check("ptime_rw", r, 32'h33);
		bus(1'b0, REG_VECTOR, 32'h0, r);
		check("vector_reg", r[15:0], 32'h1234);
		bus(1'b0, 8'h40, 32'h0, r);
		check("unmapped", r, 32'h0);
		check("hresp", hresp, 32'h0);
		$display("test jump done");
	endtask
	task automatic t_blank();
		rst(4'h0);
		mem[15'h0415] = 8'h01;
		for (int n = 0; n < 500 && red_led !== 1'b1; n++) @(posedge clk);
		repeat (20) @(posedge clk);
		check("red", red_led, 32'h1);
		check("green", green_led, 32'h0);
		check("request", handshake_line_a, 32'h0);
		$display("test blank fail done");
	endtask
	task automatic t_halt();
		rst(4'h0);
		for (int n = 0; n < 500 && green_led !== 1'b1; n++) @(posedge clk);
		repeat (60) @(posedge clk);
		check("green", green_led, 32'h1);
		check("erase_held", ee_erase, 32'h0);
		check("request", handshake_line_a, 32'h0);
		mode_select_one <= 1'b1;
		for (int n = 0; n < 300 && ew_last == 0; n++) @(posedge clk);
		check("erase_len", ew_last, ERASE_N);
		repeat (600) @(posedge clk);
		check("sec_clear", sec_n, 32'h1);
		$display("test halt done");
	endtask
	// Second mode stretches the pulse through the pulse time register
	task automatic t_prog(input logic byp, input logic [3:0] m);
		logic [31:0] r;
		int b0;
		bypass <= byp;
		rst(m);
		b0 = bad;
		bus(1'b1, REG_PTIME, 32'h19, r);
		for (int n = 0; n < 12000; n++) begin
			bus(1'b0, REG_STATUS, 32'h0, r);
			if (r[4:0] === S_DONE)
				break;
		end
		repeat (4) @(posedge clk);
		check("latch_count", we_n, 32'h10);
		check("pulse_len", pw_last, m[1] ? 25 : PROG_N);
		check("ee_program", pee_n, 32'h0);
		check("blink", tog > 1, 32'h1);
		check("green", green_led, 32'h1);
		check("red", red_led, 32'h0);
		check("source_faults", bad - b0, 32'h0);
		for (int i = 0; i < 16; i++)
			check("eprom", mem[LO + 15'(16 + i)], {4'hA, 4'(i)});
		$display("test program done");
	endtask
	// Verify-only mode against an unprogrammed array must flag red
	task automatic t_verify();
		rst(4'hA);
		for (int n = 0; n < 6000 && red_led !== 1'b1; n++) @(posedge clk);
		check("verify_red", red_led, 32'h1);
		check("verify_green", green_led, 32'h0);
		check("verify_writes", we_n, 32'h0);
		$display("test verify done");
	endtask
	task automatic t_serial();
		rst(4'hC);
		repeat (8) @(posedge clk);
		send(8'h03);
		send(8'h11);
		send(8'h22);
		send(8'h33);
		for (int n = 0; n < 100 && ex_n == 0; n++) @(posedge clk);
		check("exec", ex_n, 32'h1);
		check("ram_writes", ram_n, 32'h3);
		check("ram_base", mem[RAM_BASE], 32'h11);
		check("ram_top", mem[RAM_BASE + 15'h2], 32'h33);
		check("redirect", vector_redirect, 32'h1);
		for (int i = 0; i < 7; i++) begin
			int_index <= 3'(i);
			repeat (3) @(posedge clk);
			check("pseudo", pseudo_vector,
				i < 6 ? 32'h54 + 32'(3 * i) : 32'h0);
		end
		rst(4'hC);
		repeat (8) @(posedge clk);
		send(COUNT_LIMIT);
		send(8'h44);
		send(8'h55);
		repeat (30) @(posedge clk);
		check("early_exec", ex_n, 32'h0);
		for (int n = 0; n < 60 && ex_n == 0; n++) @(posedge clk);
		check("idle_exec", ex_n, 32'h1);
		check("ram_writes", ram_n, 32'h2);
		check("ram_base", mem[RAM_BASE], 32'h44);
		$display("test serial done");
	endtask
	////////////////////////////////////////
	initial begin
		{clk, irq_elevated, capture_input_one, rx_valid, bypass} = '0;
		{mode_select_one, mode_select_two, mode_select_three} = '0;
		{mode_select_four, hsel, hwrite, green_d} = '0;
		{rx_data, int_index, haddr, htrans, hwdata} = '0;
		{err_total, compares, cyc, pw, ew} = '0;
		sys_rst = 1'b1;
		t_jump();
		t_blank();
		t_halt();
		t_prog(1'b1, 4'h1);
		t_prog(1'b0, 4'h3);
		t_verify();
		t_serial();
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
